// >>> design/fsd_defs.svh
// Constants for the floating-point stack data-transfer block
// Behaviour
// - Unnormal or pseudo-NaN/infinity operand raises invalid
// - Pseudo-denormal operand accepted, denormal exception signalled
// - No result ever has pseudo-denormal encoding
// - Only escape bytes d8 to df reach unit
// - No immediate operand field is ever decoded
// - Registers addressed relative to current stack top
// - Real load widens memory operand, pushes it
// - Real load from register pushes copy
// - Integer load converts and pushes
// - Packed decimal load converts and pushes
// - Plain stores write top, stack unchanged
// - Pop tags top empty, top plus one
// - Real store-pop to register copies, then pops
// - Swap exchanges selected entry with top
// - Conditional move copies only when condition holds
// - Conditions decoded from carry, zero, parity flags
// - Conditional move support reported for identification
// - Masked invalid integer store writes indefinite
// - Masked denormal single/double normalized on widening
`ifndef FSD_DEFS_SVH
`define FSD_DEFS_SVH
`define FSD_ESCAPE_LO   8'hd8
`define FSD_ESCAPE_HI   8'hdf
`define FSD_EXP_MAX     15'h7fff
`define FSD_EXT_BIAS    15'h3fff
`define FSD_SGL_DEN_EXP 15'h3f81
`define FSD_DBL_DEN_EXP 15'h3c01
`define FSD_INT_EXP     15'h403e
`define FSD_SGL_UBIAS   127
`define FSD_DBL_UBIAS   1023
`define FSD_REAL_INDEF  80'hffff_c000_0000_0000_0000
`define FSD_BCD_INDEF   80'hffff_c000_0000_0000_0000
`define FSD_BCD_MAX     64'h0de0_b6b3_a763_ffff
`define FSD_TOP_RST     3'h0
`define FSD_TAG_RST     8'hff
`endif

// >>> design/fsd_pkg.sv
// Types and encoding helpers for the floating-point stack data-transfer block
package fsd_pkg;
	typedef enum logic [3:0] {
		OP_PUSH_REAL_LOAD    = 4'h0,
		OP_PUSH_INTEGER_LOAD = 4'h1,
		OP_PUSH_BCD_LOAD     = 4'h2,
		OP_STORE_REAL        = 4'h3,
		OP_STORE_INTEGER     = 4'h4,
		OP_STORE_REAL_POP    = 4'h5,
		OP_STORE_INTEGER_POP = 4'h6,
		OP_STORE_BCD_POP     = 4'h7,
		OP_SWAP_WITH_TOP     = 4'h8,
		OP_COND_MOVE_TO_TOP  = 4'h9
	} fsd_op_t;
	typedef enum logic [2:0] {
		FMT_SINGLE = 3'h0, FMT_DOUBLE = 3'h1, FMT_EXT = 3'h2,
		FMT_INT16 = 3'h3, FMT_INT32 = 3'h4, FMT_INT64 = 3'h5, FMT_BCD = 3'h6
	} fsd_fmt_t;
	typedef enum logic [2:0] {
		CC_B = 3'h0, CC_NB = 3'h1, CC_E = 3'h2, CC_NE = 3'h3,
		CC_BE = 3'h4, CC_NBE = 3'h5, CC_U = 3'h6, CC_NU = 3'h7
	} fsd_cond_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} fsd_state_t;
	typedef struct packed {
		logic [7:0]  escape_byte;
		fsd_op_t     op;
		logic        use_reg;
		logic [2:0]  reg_sel;
		fsd_fmt_t    fmt;
		fsd_cond_t   cond;
		logic [79:0] mem_data;
	} fsd_req_t;
	typedef struct packed {
		logic carry_flag;
		logic zero_flag;
		logic parity_flag;
	} fsd_flags_t;
	typedef struct packed {
		logic        valid;
		fsd_fmt_t    fmt;
		logic [79:0] data;
	} fsd_memwr_t;
	typedef struct packed {
		logic invalid;
		logic denormal;
	} fsd_exc_t;

	function automatic logic is_unsupported(input logic [79:0] x);
		return (x[78:64] != 15'h0000) && !x[63];
	endfunction

	function automatic logic is_pseudo_denorm(input logic [79:0] x);
		return (x[78:64] == 15'h0000) && x[63];
	endfunction

	// Same value, canonical encoding: exponent 1 with integer bit set
	function automatic logic [79:0] sanitize(input logic [79:0] x);
		return is_pseudo_denorm(x) ? {x[79], 15'h0001, x[63:0]} : x;
	endfunction
endpackage

// >>> design/fsd_widen.sv
// Widens memory operands of every load format to the 80-bit extended format
`timescale 1ns/1ps
`include "fsd_defs.svh"
module fsd_widen (
	input  wire fsd_pkg::fsd_fmt_t fmt,
	input  wire logic [79:0]       raw,
	output logic [79:0]            ext,
	output logic                   denormal,
	output logic                   unsupported
);
	function automatic logic [6:0] lzc(input logic [63:0] v);
		logic [6:0] n;
		n = 7'h40;
		for (int i = 0; i < 64; i++) begin
			if (v[i])
				n = 7'(63 - i);
		end
		return n;
	endfunction

	function automatic logic [79:0] norm(input logic s, input logic [63:0] m, input logic [14:0] ebase);
		logic [6:0] lz;
		lz = lzc(m);
		if (m == 64'h0)
			return {s, 79'h0};
		return {s, 15'(ebase - {8'h00, lz}), 64'(m << lz)};
	endfunction

	logic [63:0] ival;
	logic [63:0] bin;

	always_comb begin
		ext = '0;
		denormal = 1'b0;
		unsupported = 1'b0;
		ival = '0;
		bin = '0;
		unique case (fmt)
			fsd_pkg::FMT_SINGLE: begin
				if (raw[30:23] == 8'hff)
					ext = {raw[31], `FSD_EXP_MAX, 1'b1, raw[22:0], 40'h0};
				else if (raw[30:23] == 8'h00) begin
					denormal = raw[22:0] != 23'h0;
					ext = norm(raw[31], {1'b0, raw[22:0], 40'h0}, `FSD_SGL_DEN_EXP);
				end else
					ext = {raw[31], 15'(raw[30:23] - `FSD_SGL_UBIAS + `FSD_EXT_BIAS), 1'b1, raw[22:0], 40'h0};
			end
			fsd_pkg::FMT_DOUBLE: begin
				if (raw[62:52] == 11'h7ff)
					ext = {raw[63], `FSD_EXP_MAX, 1'b1, raw[51:0], 11'h0};
				else if (raw[62:52] == 11'h000) begin
					denormal = raw[51:0] != 52'h0;
					ext = norm(raw[63], {1'b0, raw[51:0], 11'h0}, `FSD_DBL_DEN_EXP);
				end else
					ext = {raw[63], 15'(raw[62:52] - `FSD_DBL_UBIAS + `FSD_EXT_BIAS), 1'b1, raw[51:0], 11'h0};
			end
			fsd_pkg::FMT_EXT: begin
				ext = raw;
				unsupported = fsd_pkg::is_unsupported(raw);
				denormal = fsd_pkg::is_pseudo_denorm(raw) || (raw[78:64] == 15'h0000 && raw[62:0] != 63'h0);
			end
			fsd_pkg::FMT_BCD: begin
				for (int d = 17; d >= 0; d--)
					bin = 64'(bin * 64'd10) + {60'h0, raw[d*4 +: 4]};
				ext = norm(raw[79], bin, `FSD_INT_EXP);
			end
			default: begin
				if (fmt == fsd_pkg::FMT_INT16)
					ival = {{48{raw[15]}}, raw[15:0]};
				else if (fmt == fsd_pkg::FMT_INT32)
					ival = {{32{raw[31]}}, raw[31:0]};
				else
					ival = raw[63:0];
				ext = norm(ival[63], ival[63] ? 64'(-ival) : ival, `FSD_INT_EXP);
			end
		endcase
	end
endmodule

// >>> design/fsd_core.sv
// Floating-point register stack with data-transfer instruction execution
`timescale 1ns/1ps
`include "fsd_defs.svh"
module fsd_core #(
	parameter bit HAS_COND_MOVE = 1'b1
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 req_valid,
	input  wire fsd_pkg::fsd_req_t    req,
	input  wire fsd_pkg::fsd_flags_t  processor_flag_word,
	input  wire logic                 invalid_mask,
	input  wire logic                 denormal_mask,
	output logic                      req_ready,
	output logic                      done,
	output logic                      not_fp,
	output fsd_pkg::fsd_memwr_t       mem_wr,
	output fsd_pkg::fsd_exc_t         exc,
	output logic [2:0]                top_ptr,
	output logic [7:0]                tag_empty,
	output logic [79:0]               top_value,
	output logic                      cond_move_supported
);
	fsd_pkg::fsd_state_t state_r;
	fsd_pkg::fsd_req_t   req_r;
	fsd_pkg::fsd_flags_t flags_r;
	logic [79:0]         stk_r [8];
	logic [79:0]         stk_nxt [8];
	logic [2:0]          top_r;
	logic [2:0]          top_nxt;
	logic [7:0]          tag_r;
	logic [7:0]          tag_nxt;
	logic [2:0]          sel;
	logic [79:0]         top_cur;
	logic [79:0]         val;
	logic                push_go;
	logic                pop_go;
	logic                inv;
	logic                den;
	logic                accept;
	logic                escape_ok;
	fsd_pkg::fsd_memwr_t wr_nxt;
	fsd_pkg::fsd_fmt_t   wid_fmt;
	logic [79:0]         wid_ext;
	logic                wid_den;
	logic                wid_unsup;

	// Register operands are offsets from the top, never physical numbers
	assign sel = 3'(top_r + req_r.reg_sel);
	assign top_cur = stk_r[top_r];
	// The request carries no immediate field at all, so none can be decoded
	assign escape_ok = req.escape_byte >= `FSD_ESCAPE_LO && req.escape_byte <= `FSD_ESCAPE_HI;
	assign accept = req_valid && req_ready && escape_ok;
	assign wid_fmt = (req_r.op == fsd_pkg::OP_PUSH_BCD_LOAD) ? fsd_pkg::FMT_BCD : req_r.fmt;

	fsd_widen u_widen (
		.fmt         (wid_fmt),
		.raw         (req_r.mem_data),
		.ext         (wid_ext),
		.denormal    (wid_den),
		.unsupported (wid_unsup)
	);

	function automatic logic cond_true(input fsd_pkg::fsd_cond_t c, input fsd_pkg::fsd_flags_t f);
		logic r;
		unique case (c[2:1])
			2'h0: r = f.carry_flag;
			2'h1: r = f.zero_flag;
			2'h2: r = f.carry_flag || f.zero_flag;
			default: r = f.parity_flag;
		endcase
		return c[0] ? !r : r;
	endfunction

	// Truncates toward zero; underflow flushes to signed zero
	function automatic logic [79:0] narrow(input logic [79:0] x, input logic dbl);
		int ue;
		int lo;
		int hi;
		logic [79:0] r;
		ue = int'(x[78:64]) - int'(`FSD_EXT_BIAS);
		lo = dbl ? 1 - `FSD_DBL_UBIAS : 1 - `FSD_SGL_UBIAS;
		hi = dbl ? `FSD_DBL_UBIAS : `FSD_SGL_UBIAS;
		if (dbl) begin
			if (x[78:64] == `FSD_EXP_MAX)
				r = {16'h0, x[79], 11'h7ff, x[62:11]};
			else if (x[78:64] == 15'h0000 || ue < lo)
				r = {16'h0, x[79], 63'h0};
			else if (ue > hi)
				r = {16'h0, x[79], 11'h7ff, 52'h0};
			else
				r = {16'h0, x[79], 11'(ue + hi), x[62:11]};
		end else begin
			if (x[78:64] == `FSD_EXP_MAX)
				r = {48'h0, x[79], 8'hff, x[62:40]};
			else if (x[78:64] == 15'h0000 || ue < lo)
				r = {48'h0, x[79], 31'h0};
			else if (ue > hi)
				r = {48'h0, x[79], 8'hff, 23'h0};
			else
				r = {48'h0, x[79], 8'(ue + hi), x[62:40]};
		end
		return r;
	endfunction

	// Returns {invalid, value}; value already holds the indefinite on invalid
	function automatic logic [64:0] to_int(input logic [79:0] x, input fsd_pkg::fsd_fmt_t f);
		logic [63:0] maxp;
		logic [63:0] mag;
		logic [63:0] v;
		logic        bad;
		int          sh;
		maxp = (f == fsd_pkg::FMT_INT16) ? 64'h7fff :
			(f == fsd_pkg::FMT_INT32) ? 64'h7fff_ffff : 64'h7fff_ffff_ffff_ffff;
		sh = int'(x[78:64]) - int'(`FSD_EXT_BIAS);
		bad = 1'b0;
		mag = '0;
		if (x[78:64] == `FSD_EXP_MAX || fsd_pkg::is_unsupported(x) || sh > 63)
			bad = 1'b1;
		else if (sh >= 0)
			mag = x[63:0] >> (63 - sh);
		if (!bad && mag > 64'(maxp + {63'h0, x[79]}))
			bad = 1'b1;
		v = x[79] ? 64'(-mag) : mag;
		if (bad)
			v = 64'(maxp + 64'h1);
		return {bad, v & {maxp[62:0], 1'b1}};
	endfunction

	function automatic logic [80:0] to_bcd(input logic [79:0] x);
		logic [64:0] iv;
		logic [63:0] mag;
		logic [71:0] b;
		iv = to_int(x, fsd_pkg::FMT_INT64);
		mag = iv[63] ? 64'(-iv[63:0]) : iv[63:0];
		b = '0;
		if (iv[64] || mag > `FSD_BCD_MAX)
			return {1'b1, `FSD_BCD_INDEF};
		for (int i = 63; i >= 0; i--) begin
			for (int d = 0; d < 18; d++) begin
				if (b[d*4 +: 4] >= 4'h5)
					b[d*4 +: 4] = 4'(b[d*4 +: 4] + 4'h3);
			end
			b = {b[70:0], mag[i]};
		end
		return {1'b0, x[79], 7'h00, b};
	endfunction

	always_comb begin
		logic [80:0] cv;
		logic        is_pop;
		cv = '0;
		is_pop = 1'b0;
		stk_nxt = stk_r;
		tag_nxt = tag_r;
		top_nxt = top_r;
		wr_nxt = '0;
		val = '0;
		push_go = 1'b0;
		pop_go = 1'b0;
		inv = 1'b0;
		den = 1'b0;
		if (state_r == fsd_pkg::ST_EXEC) begin
			unique case (req_r.op)
				fsd_pkg::OP_PUSH_REAL_LOAD: begin
					if (req_r.use_reg) begin
						val = stk_r[sel];
						push_go = 1'b1;
					end else begin
						inv = wid_unsup;
						den = wid_den;
						val = inv ? `FSD_REAL_INDEF : wid_ext;
						push_go = !inv || invalid_mask;
					end
				end
				fsd_pkg::OP_PUSH_INTEGER_LOAD, fsd_pkg::OP_PUSH_BCD_LOAD: begin
					val = wid_ext;
					push_go = 1'b1;
				end
				fsd_pkg::OP_STORE_REAL, fsd_pkg::OP_STORE_REAL_POP: begin
					is_pop = req_r.op == fsd_pkg::OP_STORE_REAL_POP;
					if (req_r.use_reg && is_pop) begin
						stk_nxt[sel] = fsd_pkg::sanitize(top_cur);
						tag_nxt[sel] = 1'b0;
						pop_go = 1'b1;
					end else begin
						inv = fsd_pkg::is_unsupported(top_cur);
						den = fsd_pkg::is_pseudo_denorm(top_cur);
						wr_nxt.valid = !inv || invalid_mask;
						wr_nxt.fmt = req_r.fmt;
						if (inv)
							wr_nxt.data = `FSD_REAL_INDEF;
						else if (req_r.fmt == fsd_pkg::FMT_EXT)
							wr_nxt.data = fsd_pkg::sanitize(top_cur);
						else
							wr_nxt.data = narrow(top_cur, req_r.fmt == fsd_pkg::FMT_DOUBLE);
						pop_go = is_pop && wr_nxt.valid;
					end
				end
				fsd_pkg::OP_STORE_INTEGER, fsd_pkg::OP_STORE_INTEGER_POP: begin
					cv = {to_int(top_cur, req_r.fmt), 16'h0};
					inv = cv[80];
					den = fsd_pkg::is_pseudo_denorm(top_cur);
					wr_nxt.valid = !inv || invalid_mask;
					wr_nxt.fmt = req_r.fmt;
					wr_nxt.data = {16'h0, cv[79:16]};
					pop_go = req_r.op == fsd_pkg::OP_STORE_INTEGER_POP && wr_nxt.valid;
				end
				fsd_pkg::OP_STORE_BCD_POP: begin
					cv = to_bcd(top_cur);
					inv = cv[80];
					wr_nxt.valid = !inv || invalid_mask;
					wr_nxt.fmt = fsd_pkg::FMT_BCD;
					wr_nxt.data = cv[79:0];
					pop_go = wr_nxt.valid;
				end
				fsd_pkg::OP_SWAP_WITH_TOP: begin
					stk_nxt[sel] = top_cur;
					stk_nxt[top_r] = stk_r[sel];
				end
				fsd_pkg::OP_COND_MOVE_TO_TOP: begin
					if (cond_true(req_r.cond, flags_r))
						stk_nxt[top_r] = stk_r[sel];
				end
				default: ;
			endcase
			if (push_go) begin
				top_nxt = 3'(top_r - 3'h1);
				stk_nxt[top_nxt] = fsd_pkg::sanitize(val);
				tag_nxt[top_nxt] = 1'b0;
			end
			if (pop_go) begin
				tag_nxt[top_r] = 1'b1;
				top_nxt = 3'(top_r + 3'h1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= fsd_pkg::ST_IDLE;
			req_ready <= 1'b1;
			req_r <= '0;
			flags_r <= '0;
		end else begin
			unique case (state_r)
				fsd_pkg::ST_IDLE: begin
					if (accept) begin
						state_r <= fsd_pkg::ST_EXEC;
						req_ready <= 1'b0;
						req_r <= req;
						flags_r <= processor_flag_word;
					end
				end
				fsd_pkg::ST_EXEC: begin
					state_r <= fsd_pkg::ST_IDLE;
					req_ready <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < 8; i++)
				stk_r[i] <= '0;
			top_r <= `FSD_TOP_RST;
			tag_r <= `FSD_TAG_RST;
			top_value <= '0;
		end else begin
			stk_r <= stk_nxt;
			top_r <= top_nxt;
			tag_r <= tag_nxt;
			top_value <= stk_nxt[top_nxt];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			done <= 1'b0;
			not_fp <= 1'b0;
			mem_wr <= '0;
			exc <= '0;
			cond_move_supported <= 1'b0;
		end else begin
			done <= state_r == fsd_pkg::ST_EXEC;
			// Non-escape opcodes are turned away without occupying the unit
			not_fp <= req_valid && req_ready && !escape_ok;
			mem_wr <= wr_nxt;
			exc.invalid <= inv;
			exc.denormal <= den;
			cond_move_supported <= HAS_COND_MOVE;
		end
	end
	assign top_ptr = top_r;
	assign tag_empty = tag_r;

	a_escape_gate: assert property (@(posedge core_clk) disable iff (srst)
		req_valid && req_ready && !escape_ok |=> not_fp && state_r == fsd_pkg::ST_IDLE)
		else $error("non-escape opcode was not rejected");
	a_pop_tagging: assert property (@(posedge core_clk) disable iff (srst)
		pop_go && !push_go |=> top_r == 3'($past(top_r) + 3'h1) && tag_r[$past(top_r)])
		else $error("pop did not empty top and advance pointer");
	a_push_top: assert property (@(posedge core_clk) disable iff (srst)
		push_go |=> top_r == 3'($past(top_r) - 3'h1) && !tag_r[top_r] && top_value == fsd_pkg::sanitize($past(val)))
		else $error("push did not place value at new top");
	a_no_pseudo: assert property (@(posedge core_clk) disable iff (srst)
		done |-> !fsd_pkg::is_pseudo_denorm(top_value))
		else $error("pseudo-denormal encoding produced");
	a_int_indef: assert property (@(posedge core_clk) disable iff (srst)
		mem_wr.valid && exc.invalid && mem_wr.fmt inside {fsd_pkg::FMT_INT16, fsd_pkg::FMT_INT32, fsd_pkg::FMT_INT64}
		|-> mem_wr.data == ((mem_wr.fmt == fsd_pkg::FMT_INT16) ? 80'h8000 :
		(mem_wr.fmt == fsd_pkg::FMT_INT32) ? 80'h8000_0000 : 80'h8000_0000_0000_0000))
		else $error("masked invalid integer store lacks indefinite");
	a_cond_keep: assert property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && req_r.op == fsd_pkg::OP_COND_MOVE_TO_TOP
		&& !cond_true(req_r.cond, flags_r) |=> top_value == $past(top_cur))
		else $error("failed condition altered stack top");
	a_store_keep: assert property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && (req_r.op == fsd_pkg::OP_STORE_REAL || req_r.op == fsd_pkg::OP_STORE_INTEGER)
		|=> top_r == $past(top_r) && tag_r == $past(tag_r))
		else $error("plain store changed the stack");
	a_unsup_inv: assert property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && req_r.op == fsd_pkg::OP_PUSH_REAL_LOAD && !req_r.use_reg
		&& req_r.fmt == fsd_pkg::FMT_EXT && fsd_pkg::is_unsupported(req_r.mem_data) |=> exc.invalid && done)
		else $error("unsupported operand did not raise invalid");
	a_den_norm: assert property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && req_r.op == fsd_pkg::OP_PUSH_REAL_LOAD && !req_r.use_reg && wid_den
		&& denormal_mask && (req_r.fmt == fsd_pkg::FMT_SINGLE || req_r.fmt == fsd_pkg::FMT_DOUBLE) |=> top_value[63])
		else $error("masked denormal load not normalized");
	a_done_timing: assert property (@(posedge core_clk) disable iff (srst)
		accept |=> !req_ready ##1 done && req_ready)
		else $error("done not one cycle after execution");
	c_push: cover property (@(posedge core_clk) disable iff (srst) push_go);
	c_pop_store: cover property (@(posedge core_clk) disable iff (srst) pop_go && wr_nxt.valid);
	c_cmov_taken: cover property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && req_r.op == fsd_pkg::OP_COND_MOVE_TO_TOP && cond_true(req_r.cond, flags_r));
	c_swap: cover property (@(posedge core_clk) disable iff (srst)
		state_r == fsd_pkg::ST_EXEC && req_r.op == fsd_pkg::OP_SWAP_WITH_TOP);
endmodule

// >>> tb/fsd_mem_model.sv
// Memory-side partner: records every store that the block writes out
`timescale 1ns/1ps
module fsd_mem_model (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire fsd_pkg::fsd_memwr_t mem_wr,
	output logic [15:0]              wr_count,
	output logic [79:0]              last_data
);
	// Counting writes lets the bench prove that a real store-pop to a register left memory alone
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_count  <= 16'h0000;
			last_data <= 80'h0;
		end else if (mem_wr.valid) begin
			wr_count  <= wr_count + 16'h0001;
			last_data <= mem_wr.data;
		end
	end
endmodule

// >>> tb/tb_fp_stack_data_transfer.sv
// Self-checking bench for the stack data-transfer block
`timescale 1ns/1ps
module tb_fp_stack_data_transfer;
	localparam logic [79:0] ONE   = 80'h3fff_8000_0000_0000_0000;
	localparam logic [79:0] TWO   = 80'h4000_8000_0000_0000_0000;
	localparam logic [79:0] INDEF = 80'hffff_c000_0000_0000_0000;
	logic                core_clk = 1'b0;
	logic                srst = 1'b1;
	logic                req_valid = 1'b0;
	fsd_pkg::fsd_req_t   req = '0;
	fsd_pkg::fsd_flags_t processor_flag_word = '0;
	logic                invalid_mask = 1'b1;
	logic                denormal_mask = 1'b1;
	logic                req_ready, done, not_fp, cond_move_supported;
	fsd_pkg::fsd_memwr_t mem_wr, got_wr;
	fsd_pkg::fsd_exc_t   exc, got_exc;
	logic [2:0]          top_ptr;
	logic [7:0]          tag_empty;
	logic [79:0]         top_value, last_data;
	logic [15:0]         wr_count;
	logic                got_nf;
	int                  failures = 0;
	int                  compares = 0;
	int                  cycles = 0;

	fsd_core dut_u (
		.core_clk            (core_clk),
		.srst                (srst),
		.req_valid           (req_valid),
		.req                 (req),
		.processor_flag_word (processor_flag_word),
		.invalid_mask        (invalid_mask),
		.denormal_mask       (denormal_mask),
		.req_ready           (req_ready),
		.done                (done),
		.not_fp              (not_fp),
		.mem_wr              (mem_wr),
		.exc                 (exc),
		.top_ptr             (top_ptr),
		.tag_empty           (tag_empty),
		.top_value           (top_value),
		.cond_move_supported (cond_move_supported)
	);

	fsd_mem_model mem_u (
		.core_clk  (core_clk),
		.srst      (srst),
		.mem_wr    (mem_wr),
		.wr_count  (wr_count),
		.last_data (last_data)
	);

	always #2 core_clk = ~core_clk;

	task automatic end_of_test();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// A hang in the handshake must still reach the verdict
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("MISMATCH %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic chk80(input logic [79:0] g, input logic [79:0] e, input string m);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// One request; returns in the cycle where done or the refusal is visible
	task automatic issue(input logic [7:0] opc, input fsd_pkg::fsd_op_t op, input logic ur, input logic [2:0] sel,
			input fsd_pkg::fsd_fmt_t fmt, input fsd_pkg::fsd_cond_t cc, input logic [79:0] d);
		int   n;
		logic ok;
		ok = opc >= 8'hd8 && opc <= 8'hdf;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req       <= '{opc, op, ur, sel, fmt, cc, d};
		@(posedge core_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 6; n++) begin
			#1;
			if (done === 1'b1 || not_fp === 1'b1)
				break;
			@(posedge core_clk);
		end
		got_nf  = not_fp;
		got_exc = exc;
		got_wr  = mem_wr;
		chk8({req_ready, 5'h0, n[1:0]}, {1'b1, 5'h0, (ok ? 2'h1 : 2'h0)}, "answer timing");
		if (n == 6) begin
			failures++;
			$display("MISMATCH %0t no answer", $time);
		end
	endtask

	task automatic s_reset();
		chk8(tag_empty, 8'hff, "tags after reset");
		chk8({5'h0, top_ptr}, 8'h00, "top after reset");
		chk8({7'h0, cond_move_supported}, 8'h01, "cond move support");
	endtask

	task automatic s_loads();
		issue(8'hd8, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, ONE);
		chk80(top_value, ONE, "ext load");
		chk8({5'h0, top_ptr}, 8'h07, "push wraps below zero");
		issue(8'hd9, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_SINGLE, fsd_pkg::CC_B, 80'h3f80_0000);
		chk80(top_value, ONE, "single widened");
		issue(8'hdf, fsd_pkg::OP_PUSH_INTEGER_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_INT16, fsd_pkg::CC_B, 80'h1);
		chk80(top_value, ONE, "integer load");
		issue(8'hdf, fsd_pkg::OP_PUSH_BCD_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_BCD, fsd_pkg::CC_B, 80'h2);
		chk80(top_value, TWO, "bcd load");
		chk8(tag_empty, 8'h0f, "tags after four pushes");
		issue(8'hd9, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b1, 3'h1, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h0);
		chk80(top_value, ONE, "register copy pushed");
		chk8({5'h0, top_ptr}, 8'h03, "top after copy");
	endtask

	task automatic s_swap_store();
		issue(8'hd9, fsd_pkg::OP_SWAP_WITH_TOP, 1'b1, 3'h1, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h0);
		chk80(top_value, TWO, "swap");
		issue(8'hdd, fsd_pkg::OP_STORE_REAL, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h0);
		chk80(got_wr.data, TWO, "store data");
		chk8({got_wr.valid, 4'h0, got_wr.fmt}, {1'b1, 4'h0, fsd_pkg::FMT_EXT}, "store strobe");
		chk8({5'h0, top_ptr}, 8'h03, "store keeps top");
		issue(8'hdf, fsd_pkg::OP_STORE_INTEGER_POP, 1'b0, 3'h0, fsd_pkg::FMT_INT16, fsd_pkg::CC_B, 80'h0);
		chk80(got_wr.data, 80'h2, "integer store");
		chk8({5'h0, top_ptr}, 8'h04, "pop raises top");
		chk8(tag_empty, 8'h0f, "pop marks empty");
	endtask

	// Source alternates so that a wrongful move or a missed move always shows
	task automatic s_cond();
		logic [79:0] exp_v;
		logic        take;
		logic [3:0]  f;
		exp_v = ONE;
		for (int c = 0; c < 8; c++) begin
			for (f = 4'h0; f < 4'h8; f++) begin
				case (c)
					0: take = f[2];
					1: take = !f[2];
					2: take = f[1];
					3: take = !f[1];
					4: take = f[2] | f[1];
					5: take = !(f[2] | f[1]);
					6: take = f[0];
					default: take = !f[0];
				endcase
				@(posedge core_clk);
				processor_flag_word <= f[2:0];
				issue(8'hda, fsd_pkg::OP_COND_MOVE_TO_TOP, 1'b1, (exp_v == ONE) ? 3'h7 : 3'h1,
					fsd_pkg::FMT_EXT, fsd_pkg::fsd_cond_t'(c), 80'h0);
				if (take)
					exp_v = (exp_v == ONE) ? TWO : ONE;
				chk80(top_value, exp_v, "conditional move");
			end
		end
	endtask

	task automatic s_refuse();
		logic [7:0] bad [3];
		bad = '{8'h90, 8'hd7, 8'he0};
		for (int i = 0; i < 3; i++) begin
			issue(bad[i], fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, TWO);
			chk8({7'h0, got_nf}, 8'h01, "non escape refused");
			chk8({5'h0, top_ptr}, 8'h04, "refused leaves stack");
		end
	endtask

	task automatic s_special();
		logic [15:0] cnt;
		issue(8'hdb, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h4000_0000_0000_0000_0000);
		chk8({7'h0, got_exc.invalid}, 8'h01, "unnormal invalid");
		chk80(top_value, INDEF, "masked unnormal");
		issue(8'hdf, fsd_pkg::OP_STORE_INTEGER, 1'b0, 3'h0, fsd_pkg::FMT_INT32, fsd_pkg::CC_B, 80'h0);
		chk80(got_wr.data, 80'h8000_0000, "integer indefinite");
		@(posedge core_clk);
		invalid_mask <= 1'b0;
		issue(8'hdb, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h7fff_0000_0000_0000_0000);
		chk8({got_exc.invalid, 4'h0, top_ptr}, 8'h83, "unmasked pseudo inf");
		@(posedge core_clk);
		invalid_mask <= 1'b1;
		issue(8'hdb, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h0000_8000_0000_0000_0001);
		chk8({7'h0, got_exc.denormal}, 8'h01, "pseudo denormal flag");
		chk80(top_value, 80'h0001_8000_0000_0000_0001, "pseudo denormal kept canonical");
		issue(8'hd9, fsd_pkg::OP_PUSH_REAL_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_SINGLE, fsd_pkg::CC_B, 80'h1);
		chk8({7'h0, got_exc.denormal}, 8'h01, "single denormal flag");
		chk80(top_value, 80'h3f6a_8000_0000_0000_0000, "single denormal normalized");
		cnt = wr_count;
		issue(8'hdd, fsd_pkg::OP_STORE_REAL_POP, 1'b1, 3'h1, fsd_pkg::FMT_EXT, fsd_pkg::CC_B, 80'h0);
		chk80(top_value, 80'h3f6a_8000_0000_0000_0000, "copy then pop");
		chk8({5'h0, top_ptr}, 8'h02, "register pop top");
		chk8({7'h0, got_wr.valid}, 8'h00, "no write strobe");
		// The model counts one edge after the strobe
		@(posedge core_clk);
		#1;
		chk8(wr_count[7:0], cnt[7:0], "no memory write");
		chk80(last_data, 80'h8000_0000, "memory holds indefinite");
	endtask

	task automatic s_bcd_store();
		issue(8'hdd, fsd_pkg::OP_STORE_REAL, 1'b0, 3'h0, fsd_pkg::FMT_DOUBLE, fsd_pkg::CC_B, 80'h0);
		chk80(got_wr.data, 80'h36a0_0000_0000_0000, "double store");
		issue(8'hdf, fsd_pkg::OP_PUSH_INTEGER_LOAD, 1'b0, 3'h0, fsd_pkg::FMT_INT64, fsd_pkg::CC_B, 80'd1234);
		issue(8'hdf, fsd_pkg::OP_STORE_BCD_POP, 1'b0, 3'h0, fsd_pkg::FMT_BCD, fsd_pkg::CC_B, 80'h0);
		chk80(got_wr.data, 80'h1234, "bcd store");
		chk8({5'h0, top_ptr}, 8'h02, "bcd store pops");
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		s_reset();
		s_loads();
		s_swap_store();
		s_cond();
		s_refuse();
		s_special();
		s_bcd_store();
		end_of_test();
	end
endmodule
